// File: shared/quad_defs.vh
`ifndef QUAD_DEFS_VH
`define QUAD_DEFS_VH

// ***************************************************
// evaluation modes
// ***************************************************
`define EVAL_SINGLE    2'h0
`define EVAL_DOUBLE    2'h1
`define EVAL_QUAD      2'h2

// ***************************************************
// diagnostic byte layout
// ***************************************************
`define DIAG_SYNC_BIT  0
`define DIAG_S1_BIT    1
`define DIAG_S2_BIT    2
`define DIAG_OVF_BIT   3
`define DIAG_RESET     8'h00

// ***************************************************
// input image byte positions
// ***************************************************
`define IMG_DIAG_BYTE  1
`define IMG_HIGH_BYTE  2
`define IMG_LOW_BYTE   3

// ***************************************************
// reset values and ranges
// ***************************************************
`define COUNT_RESET    16'h0000
`define SETPOINT_RESET 16'h0000
`define COUNT_MAX      17'h07fff
`define COUNT_MIN      17'h18000

`endif

// File: rtl/pin_sync.v
`timescale 1ns/1ns
module pin_sync #(
	parameter WIDTH = 4
) (
	// clock and reset
	input  wire             clk,
	input  wire             nrst,
	// raw pins and synchronised copy
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_out
);

	reg [WIDTH-1:0] stage;

	// two flops per pin; only the second stage is ever read
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage   <= {WIDTH{1'b0}};
			pin_out <= {WIDTH{1'b0}};
		end else begin
			stage   <= pin_in;
			pin_out <= stage;
		end
	end

endmodule

// File: rtl/quad_step.v
`timescale 1ns/1ns
`include "quad_defs.vh"
module quad_step (
	// clock and reset
	input  wire       clk,
	input  wire       nrst,
	// synchronised phases and mode
	input  wire       phase_a,
	input  wire       phase_b,
	input  wire [1:0] eval_mode,
	// decoded motion
	output reg        step_up,
	output reg        step_down
);

	reg a_d;
	reg b_d;
	reg next_up;
	reg next_down;

	// previous phase levels for edge detection
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			a_d <= 1'b0;
			b_d <= 1'b0;
		end else begin
			a_d <= phase_a;
			b_d <= phase_b;
		end
	end

	// direction from which phase leads; a rising, b low means up
	always @* begin
		next_up   = 1'b0;
		next_down = 1'b0;
		case (eval_mode)
			`EVAL_SINGLE: begin
				next_up   = phase_a & ~a_d & ~phase_b; // R1
				next_down = ~phase_a & a_d & ~phase_b; // R25
			end
			`EVAL_DOUBLE: begin
				next_up   = (phase_a ^ a_d) & (phase_a ^ phase_b); // R3
				next_down = (phase_a ^ a_d) & ~(phase_a ^ phase_b); // R25
			end
			default: begin
				// quadruple: every edge of either phase
				next_up   = ((phase_a ^ a_d) & (phase_a ^ phase_b))
					| ((phase_b ^ b_d) & ~(phase_a ^ phase_b)); // R25
				next_down = ((phase_a ^ a_d) & ~(phase_a ^ phase_b))
					| ((phase_b ^ b_d) & (phase_a ^ phase_b)); // R3
			end
		endcase
		// a simultaneous change on both phases is a lost step, not a count
		if ((phase_a ^ a_d) & (phase_b ^ b_d)) begin
			next_up   = 1'b0;
			next_down = 1'b0;
		end
	end

	// registered step pulses
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			step_up   <= 1'b0;
			step_down <= 1'b0;
		end else begin
			step_up   <= next_up;
			step_down <= next_down;
		end
	end

endmodule

// File: rtl/quadrature_position_decoder.v
`timescale 1ns/1ns
`include "quad_defs.vh"
// What this block does
// R1: direction from phase relation of encoder
// R2: signed 16-bit position counter
// R3: single, double or quadruple evaluation
// R4: controller supplies signed 16-bit setpoints
// R5: setpoint taken at once when unreached
// R6: setpoint pending until enable rises when reached
// R7: sync clears count, sets sync bit 0
// R8: sync clears overflow bit 3
// R9: arm only on reference rising edge
// R10: sync needs up movement while reference high
// R11: first reference pulse after arming synchronises
// R12: after reference falls, up syncs, down aborts
// R13: controller should mask reference after approach
// R14: count up for positive, down for negative
// R15: enable rising edge arms both outputs
// R16: output sets on sync, no overflow, enable, match
// R17: setpoint one drives output one, two two
// R18: enable low clears outputs and reached bits
// R19: set output holds until enable low
// R20: count reported as two's complement
// R21: outputs reset when controller leaves run
// R22: overflow sets bit 3 and blocks switching
// R23: reached bits at diagnostic bits 1, 2
// R24: image bytes: 1 diag, 2 high, 3 low
// R25: edges counted per evaluation mode
module quadrature_position_decoder (
	// clock and reset
	input  wire        clk,
	input  wire        nrst,
	// encoder and switch pins
	input  wire        phase_a,
	input  wire        phase_b,
	input  wire        ref_pulse,
	input  wire        ref_signal,
	input  wire        enable_in,
	// configuration
	input  wire [1:0]  eval_mode,
	input  wire        ctrl_run,
	// output image from the controller
	input  wire [15:0] setpoint1_in,
	input  wire        setpoint1_wr,
	input  wire [15:0] setpoint2_in,
	input  wire        setpoint2_wr,
	// switched outputs
	output reg         out1,
	output reg         out2,
	// input image to the controller
	output reg  [31:0] input_image,
	output wire [7:0]  diag_byte,
	output reg  [15:0] count
);

	// ***************************************************
	// synchronisation of pins
	// ***************************************************
	localparam ST_IDLE  = 4'h1;
	localparam ST_HIGH  = 4'h2;
	localparam ST_MOVED = 4'h4;
	localparam ST_LOW   = 4'h8;

	wire [4:0] pins_s;
	wire       a_s;
	wire       b_s;
	wire       refp_s;
	wire       refs_s;
	wire       en_s;
	wire       step_up;
	wire       step_down;

	pin_sync #(
		.WIDTH(5)
	) u_sync (
		.clk     (clk),
		.nrst    (nrst),
		.pin_in  ({enable_in, ref_signal, ref_pulse, phase_b, phase_a}),
		.pin_out (pins_s)
	);

	assign a_s    = pins_s[0];
	assign b_s    = pins_s[1];
	assign refp_s = pins_s[2];
	assign refs_s = pins_s[3];
	assign en_s   = pins_s[4];

	quad_step u_step (
		.clk       (clk),
		.nrst      (nrst),
		.phase_a   (a_s),
		.phase_b   (b_s),
		.eval_mode (eval_mode),
		.step_up   (step_up),
		.step_down (step_down)
	);

	// ***************************************************
	// edge detection
	// ***************************************************
	reg refs_d;
	reg refp_d;
	reg en_d;
	reg ref_seen_low;
	reg [1:0] settle;

	wire ref_rise = refs_s & ~refs_d;
	wire ref_fall = ~refs_s & refs_d;
	wire pulse_rise = refp_s & ~refp_d;
	wire en_rise = en_s & ~en_d;

	// ref_seen_low stops a reference already high at power-up from arming
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			refs_d       <= 1'b1;
			refp_d       <= 1'b0;
			en_d         <= 1'b0;
			ref_seen_low <= 1'b0;
			settle       <= 2'h0;
		end else begin
			refs_d <= refs_s;
			refp_d <= refp_s;
			en_d   <= en_s;
			settle <= {settle[0], 1'b1};
			// the synchroniser reads low until filled, so its low is not trusted before
			if (!refs_s && settle[1])
				ref_seen_low <= 1'b1; // R9
		end
	end

	// ***************************************************
	// reference approach state machine
	// ***************************************************
	reg [3:0] ref_state;
	reg [3:0] next_ref_state;
	reg       do_sync;

	// pulse only counts once up movement is known, inside or after the signal
	always @* begin
		next_ref_state = ref_state;
		do_sync        = 1'b0;
		case (ref_state)
			ST_IDLE: begin
				if (ref_rise && ref_seen_low)
					next_ref_state = ST_HIGH; // R9
			end
			ST_HIGH: begin
				if (ref_fall)
					next_ref_state = ST_LOW; // R12
				else if (step_up)
					next_ref_state = ST_MOVED; // R10
			end
			ST_MOVED: begin
				if (pulse_rise) begin
					do_sync        = 1'b1; // R11
					next_ref_state = ST_IDLE;
				end else if (ref_fall) begin
					next_ref_state = ST_LOW;
				end
			end
			ST_LOW: begin
				if (step_down)
					next_ref_state = ST_IDLE; // R12
				else if (pulse_rise && step_up) begin
					do_sync        = 1'b1;
					next_ref_state = ST_IDLE;
				end else if (step_up)
					next_ref_state = ST_MOVED; // R12
			end
			default: begin
				next_ref_state = ST_IDLE;
			end
		endcase
		// a fresh rising edge re-arms for the next approach
		if (ref_rise && ref_seen_low && !do_sync)
			next_ref_state = ST_HIGH;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			ref_state <= ST_IDLE;
		else
			ref_state <= next_ref_state;
	end

	// ***************************************************
	// position counter and flags
	// ***************************************************
	reg         sync_flag;
	reg         ovf_flag;
	wire [16:0] count_ext = {count[15], count}; // R20
	wire [16:0] count_next = step_up ? count_ext + 17'h00001
		: count_ext - 17'h00001;
	wire        leaves = (step_up && count == 16'h7fff)
		|| (step_down && count == 16'h8000); // R2

	// wraps on overflow and keeps counting; flag needs a fresh sync to clear
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count     <= `COUNT_RESET;
			sync_flag <= 1'b0;
			ovf_flag  <= 1'b0;
		end else begin
			if (do_sync) begin
				count     <= `COUNT_RESET; // R7
				sync_flag <= 1'b1; // R7
				ovf_flag  <= 1'b0; // R8
			end else if (step_up ^ step_down) begin
				count <= count_next[15:0]; // R14
				if (leaves)
					ovf_flag <= 1'b1; // R22
			end
		end
	end

	// ***************************************************
	// setpoints
	// ***************************************************
	reg [15:0] sp1;
	reg [15:0] sp2;
	reg [15:0] sp1_pend;
	reg [15:0] sp2_pend;
	reg        sp1_has;
	reg        sp2_has;
	reg        reach1;
	reg        reach2;

	// while reached, new values wait for an enable rising edge
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sp1      <= `SETPOINT_RESET;
			sp2      <= `SETPOINT_RESET;
			sp1_pend <= `SETPOINT_RESET;
			sp2_pend <= `SETPOINT_RESET;
			sp1_has  <= 1'b0;
			sp2_has  <= 1'b0;
		end else begin
			// a direct write drops any stale pending value
			if (setpoint1_wr && !reach1) begin
				sp1     <= setpoint1_in; // R5
				sp1_has <= 1'b0;
			end else if (setpoint1_wr) begin
				sp1_pend <= setpoint1_in; // R6
				sp1_has  <= 1'b1;
			end else if (en_rise && sp1_has) begin
				sp1     <= sp1_pend; // R6
				sp1_has <= 1'b0;
			end
			if (setpoint2_wr && !reach2) begin
				sp2     <= setpoint2_in; // R5
				sp2_has <= 1'b0;
			end else if (setpoint2_wr) begin
				sp2_pend <= setpoint2_in; // R6
				sp2_has  <= 1'b1;
			end else if (en_rise && sp2_has) begin
				sp2     <= sp2_pend; // R6
				sp2_has <= 1'b0;
			end
		end
	end

	// ***************************************************
	// switched outputs
	// ***************************************************
	reg  armed;
	wire allow = sync_flag && !ovf_flag && en_s && armed && ctrl_run; // R16

	// latched outputs; only enable low or leaving run clears them
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			armed  <= 1'b0;
			reach1 <= 1'b0;
			reach2 <= 1'b0;
			out1   <= 1'b0;
			out2   <= 1'b0;
		end else if (!en_s || !ctrl_run) begin
			armed  <= 1'b0; // R18
			reach1 <= 1'b0; // R21
			reach2 <= 1'b0;
			out1   <= 1'b0; // R18
			out2   <= 1'b0; // R21
		end else begin
			if (en_rise)
				armed <= 1'b1; // R15
			if (allow && count == sp1) begin
				reach1 <= 1'b1; // R17
				out1   <= 1'b1; // R19
			end
			if (allow && count == sp2) begin
				reach2 <= 1'b1; // R17
				out2   <= 1'b1; // R19
			end
		end
	end

	// ***************************************************
	// input image
	// ***************************************************
	assign diag_byte = {4'h0, ovf_flag, reach2, reach1, sync_flag}; // R23

	// byte 0 reads zero; count is already two's complement
	always @(posedge clk or negedge nrst) begin
		if (!nrst)
			input_image <= 32'h00000000;
		else
			input_image <= {8'h00, diag_byte, count}; // R24
	end

endmodule

// File: testbench/qpd_assertions.sv
`timescale 1ns/1ns
// ***
// port checker
// ***
module qpd_assertions (
	// clock and reset
	input wire        clk,
	input wire        nrst,
	// control
	input wire        ctrl_run,
	// outputs
	input wire        out1,
	input wire        out2,
	input wire [31:0] input_image,
	input wire [7:0]  diag_byte,
	input wire [15:0] count
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// image is a registered copy, one cycle behind
	a_image_count: assert property (input_image[15:0] == $past(count))
		else $error("image count wrong");
	a_image_diag: assert property (input_image[23:16] == $past(diag_byte))
		else $error("image diag wrong");
	a_spare_zero: assert property (input_image[31:24] == 8'h00 && diag_byte[7:4] == 4'h0)
		else $error("spare bits set");
	a_out1_flag: assert property (out1 == diag_byte[1])
		else $error("out1 and flag differ");
	a_out2_flag: assert property (out2 == diag_byte[2])
		else $error("out2 and flag differ");
	a_run_stop: assert property (!ctrl_run |=> !out1 && !out2)
		else $error("outputs on out of run");
	// out1 may only come on while synced and free of overflow
	a_set_cause: assert property ($rose(out1) |-> $past(diag_byte[0]) && !$past(diag_byte[3]))
		else $error("out1 set without sync");
	// sync clears to zero, otherwise one count per step
	a_count_step: assert property ($changed(count) |-> count == 16'h0000 ||
		count - $past(count) == 16'h0001 || $past(count) - count == 16'h0001)
		else $error("count jumped");
endmodule
bind quadrature_position_decoder qpd_assertions i_chk (.clk, .nrst, .ctrl_run, .out1, .out2,
	.input_image, .diag_byte, .count);

// File: testbench/encoder_model.sv
`timescale 1ns/1ns
// ***
// encoder model
// ***
module encoder_model (
	// clock
	input wire clk,
	// encoder pins
	output reg phase_a,
	output reg phase_b,
	output reg ref_pulse
);
	integer s = 0;
	// quarter steps; levels held long enough to decode
	task move(input integer n);
		repeat (n < 0 ? -n : n) begin
			s = (s + (n > 0 ? 1 : 3)) % 4;
			@(posedge clk) #1;
			phase_a = s == 1 || s == 2;
			phase_b = s > 1;
			repeat (6) @(posedge clk);
		end
	endtask
	// reference pulse with no motion around it
	task pulse;
		@(posedge clk) #1 ref_pulse = 1;
		repeat (6) @(posedge clk);
		#1 ref_pulse = 0;
		repeat (6) @(posedge clk);
	endtask
	initial {phase_a, phase_b, ref_pulse} = 3'b000;
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/1ns
`include "quad_defs.vh"
`define CHK(nm, e, v) begin n_checks = n_checks + 1; if ((v) !== (e)) begin \
	n_errors = n_errors + 1; $display("BAD %s exp %h got %h", nm, e, v); end end
// ***
// bench
// ***
module tb_top;
	reg clk = 0;
	reg nrst = 0;
	reg ref_signal = 0;
	reg enable_in = 0;
	reg ctrl_run = 1;
	reg s1_wr = 0;
	reg s2_wr = 0;
	reg [1:0] eval_mode = `EVAL_QUAD;
	reg [15:0] s1 = 16'h0000;
	reg [15:0] s2 = 16'h0000;
	wire phase_a, phase_b, ref_pulse, out1, out2;
	wire [31:0] input_image;
	wire [7:0] diag_byte;
	wire [15:0] count;
	integer n_errors = 0;
	integer n_checks = 0;
	// clock
	initial forever #10 clk = ~clk;
	encoder_model i_enc (.clk(clk), .phase_a(phase_a), .phase_b(phase_b), .ref_pulse(ref_pulse));
	quadrature_position_decoder i_dut (.clk(clk), .nrst(nrst), .phase_a(phase_a),
		.phase_b(phase_b), .ref_pulse(ref_pulse), .ref_signal(ref_signal),
		.enable_in(enable_in), .eval_mode(eval_mode), .ctrl_run(ctrl_run),
		.setpoint1_in(s1), .setpoint1_wr(s1_wr), .setpoint2_in(s2), .setpoint2_wr(s2_wr),
		.out1(out1), .out2(out2), .input_image(input_image), .diag_byte(diag_byte),
		.count(count));
	task wt(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input [15:0] a, input [15:0] b);
		s1 = a;
		s2 = b;
		s1_wr = 1;
		s2_wr = 1;
		wt(1);
		s1_wr = 0;
		s2_wr = 0;
	endtask
	// every evaluation mode, up then back down
	task t_modes;
		integer m;
		reg [15:0] c0;
		for (m = 0; m < 4; m = m + 1) begin
			eval_mode = m[1:0];
			c0 = count;
			i_enc.move(8);
			wt(8);
			`CHK("up", c0 + (m == 0 ? 16'd2 : m == 1 ? 16'd4 : 16'd8), count)
			i_enc.move(-8);
			wt(8);
			`CHK("down", c0, count)
		end
		eval_mode = `EVAL_QUAD;
	endtask
	// aborted approach, then a good one
	task t_sync;
		`CHK("pre", 8'h00, diag_byte)
		ref_signal = 1;
		wt(8);
		ref_signal = 0;
		i_enc.move(-4);
		i_enc.pulse;
		wt(8);
		`CHK("abort", 1'b0, diag_byte[`DIAG_SYNC_BIT])
		ref_signal = 1;
		i_enc.move(4);
		i_enc.pulse;
		wt(8);
		`CHK("zero", 16'h0000, count)
		`CHK("sync", 1'b1, diag_byte[`DIAG_SYNC_BIT])
		ref_signal = 0;
		wt(4);
	endtask
	// setpoints from both sides, hold, disable, rearm, stop
	task t_reach;
		wr(16'h0003, 16'hfffe);
		enable_in = 1;
		wt(8);
		`CHK("idle", 2'b00, {out2, out1})
		i_enc.move(3);
		wt(8);
		`CHK("diag1", 4'b0011, diag_byte[3:0])
		`CHK("out1", 2'b01, {out2, out1})
		i_enc.move(-5);
		wt(8);
		`CHK("image", 16'hfffe, input_image[15:0])
		`CHK("hold", 2'b11, {out2, out1})
		wr(16'hfffe, 16'h0003);
		enable_in = 0;
		i_enc.move(1);
		wt(8);
		`CHK("off", 3'b000, {out2, out1, diag_byte[1]})
		`CHK("track", 16'hffff, count)
		enable_in = 1;
		i_enc.move(-1);
		wt(8);
		`CHK("rearm", 2'b01, {out2, out1})
		ctrl_run = 0;
		wt(4);
		`CHK("stop", 2'b00, {out2, out1})
	endtask
	// reference falls first, then up movement and a pulse resync
	task t_resync;
		ref_signal = 1;
		wt(8);
		ref_signal = 0;
		wt(8);
		i_enc.move(3);
		`CHK("late", 16'h0001, count)
		i_enc.pulse;
		wt(8);
		`CHK("resync", 16'h0000, count)
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// guard against a hang
	initial begin
		#1000000;
		n_errors = n_errors + 1;
		wrap_up;
	end
	initial begin
		repeat (3) @(posedge clk);
		#1 nrst = 1;
		t_modes;
		t_sync;
		t_reach;
		t_resync;
		wrap_up;
	end
endmodule
